// *** uss_pkg.sv ***
// package: register map, field positions, reset values and link constants for the sync slave serial port
package uss_pkg;
  // register byte addresses
  localparam logic [7:0] RX_STATUS_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] TX_HOLDING_ADDR        = 8'h04;
  localparam logic [7:0] TX_STATUS_CONTROL_ADDR = 8'h08;
  localparam logic [7:0] BAUD_CONTROL_ADDR      = 8'h0c;
  localparam logic [7:0] BAUD_DIV_HIGH_ADDR     = 8'h10;
  localparam logic [7:0] BAUD_DIV_LOW_ADDR      = 8'h14;
  localparam logic [7:0] IRQ_FLAGS_ADDR         = 8'h18;
  localparam logic [7:0] IRQ_ENABLES_ADDR       = 8'h1c;
  localparam logic [7:0] IRQ_PRIORITY_ADDR      = 8'h20;
  localparam logic [7:0] RX_BUFFER_ADDR         = 8'h24;
  localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h28;
  // rx_status_control fields
  localparam int RCS_SERIAL_PORT_ENABLE = 7;
  localparam int RCS_NINE_BIT_RX        = 6;
  localparam int RCS_SINGLE_RX_ENABLE   = 5;
  localparam int RCS_CONT_RX_ENABLE     = 4;
  localparam int RCS_ADDRESS_DETECT     = 3;
  localparam int RCS_FRAMING_ERROR      = 2;
  localparam int RCS_OVERRUN_ERROR      = 1;
  localparam int RCS_RX_NINTH_BIT       = 0;
  // tx_status_control fields
  localparam int TCS_CLOCK_SOURCE_SEL   = 7;
  localparam int TCS_NINE_BIT_TX        = 6;
  localparam int TCS_TRANSMIT_ENABLE    = 5;
  localparam int TCS_SYNC_MODE          = 4;
  localparam int TCS_SEND_BREAK         = 3;
  localparam int TCS_HIGH_BAUD          = 2;
  localparam int TCS_SHIFT_REG_EMPTY    = 1;
  localparam int TCS_TX_NINTH_BIT       = 0;
  // peripheral irq fields
  localparam int IRQ_RX_BIT             = 5;
  localparam int IRQ_TX_BIT             = 4;
  // power control fields: bit0 sleep, bit1 idle
  localparam int PWR_SLEEP              = 0;
  localparam int PWR_IDLE               = 1;
  // reset values
  localparam logic [7:0] RCS_RESET      = 8'h00;
  localparam logic [7:0] TCS_RESET      = 8'h02;
  localparam logic [7:0] BAUD_CTL_RESET = 8'h40;
  localparam logic [7:0] ZERO_RESET     = 8'h00;
  // mask of writable bits in baud_control (bit5 and bit2 unimplemented)
  localparam logic [7:0] BAUD_CTL_WMASK = 8'hdb;
  // holding-to-shift move takes one instruction cycle before the flag sets
  localparam int TCY_NS                 = 16;
  localparam int CLK_NS                 = 4;
  localparam int TCY_CYCLES             = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TCY_COUNT      = 4'(TCY_CYCLES);
  // bit counter widths
  localparam logic [3:0] BITS8          = 4'h8;
  localparam logic [3:0] BITS9          = 4'h9;
  // axi responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // transmit states, gray coded
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01,
    TX_LAST  = 2'b11
  } uss_tx_e;
endpackage : uss_pkg

// *** uss_top.sv ***
// sync slave serial port: axi4-lite registers, shift registers and link sampling
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module uss_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        shift_clock_pin_i,
  input  wire logic        data_pin_i,
  output logic             data_pin_o,
  output logic             data_pin_oe,
  output logic             shift_clock_pin_o,
  output logic             shift_clock_pin_oe,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             wake_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0]    ck_sync;
    logic [1:0]    dt_sync;
    logic          ck_prev;
    logic [7:0]    rcs;
    logic [7:0]    tcs;
    logic [7:0]    baud_ctl;
    logic [7:0]    div_hi;
    logic [7:0]    div_lo;
    logic [7:0]    irq_en;
    logic [7:0]    irq_pri;
    logic [1:0]    pwr;
    logic [7:0]    tx_hold;
    logic          tx_hold_full;
    logic [8:0]    tx_shift_register;
    logic [3:0]    tx_cnt;
    uss_pkg::uss_tx_e tx_st;
    logic [3:0]    tcy_cnt;
    logic          tx_flag;
    logic [8:0]    rx_shift_register;
    logic [3:0]    rx_cnt;
    logic [7:0]    rx_buf;
    logic          rx_flag;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          dt_o;
    logic          dt_oe;
    logic          tx_irq;
    logic          rx_irq;
    logic          wake;
  } uss_state_s;
  uss_state_s st_r;
  uss_state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic       slave_on;
    logic       ck_fall;
    logic       ck_rise;
    logic       wr_fire;
    logic       rd_fire;
    logic [7:0] wb;
    logic [3:0] txbits;
    logic [3:0] rxbits;
    logic       rx_done;
    st_nxt   = st_r;
    // slave when port on, sync mode, clock source clear
    slave_on = st_r.rcs[uss_pkg::RCS_SERIAL_PORT_ENABLE] & st_r.tcs[uss_pkg::TCS_SYNC_MODE]
               & ~st_r.tcs[uss_pkg::TCS_CLOCK_SOURCE_SEL];
    // external clock edges from the synchronised pin only
    st_nxt.ck_sync = {st_r.ck_sync[0], shift_clock_pin_i};
    st_nxt.dt_sync = {st_r.dt_sync[0], data_pin_i};
    st_nxt.ck_prev = st_r.ck_sync[1];
    ck_rise  = st_r.ck_sync[1] & ~st_r.ck_prev;
    ck_fall  = ~st_r.ck_sync[1] & st_r.ck_prev;
    txbits   = st_r.tcs[uss_pkg::TCS_NINE_BIT_TX] ? uss_pkg::BITS9 : uss_pkg::BITS8;
    rxbits   = st_r.rcs[uss_pkg::RCS_NINE_BIT_RX] ? uss_pkg::BITS9 : uss_pkg::BITS8;
    rx_done  = 1'b0;
    wb       = st_r.w_data[7:0];
    wr_fire  = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    rd_fire  = s_axi_arvalid & st_r.arready;

    // axi write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.wready = 1'b0;
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // transmit shifter; shifting runs regardless of power state
    case (st_r.tx_st)
      uss_pkg::TX_IDLE:
      begin
        if (st_r.tx_hold_full && slave_on && st_r.tcs[uss_pkg::TCS_TRANSMIT_ENABLE])
        begin
          // holding word moves to shifter at once
          st_nxt.tx_shift_register          = {st_r.tcs[uss_pkg::TCS_TX_NINTH_BIT], st_r.tx_hold};
          st_nxt.tx_hold_full = 1'b0;
          st_nxt.tx_cnt       = 4'h0;
          st_nxt.tcy_cnt      = uss_pkg::TCY_COUNT;
          st_nxt.tx_st        = uss_pkg::TX_SHIFT;
          st_nxt.dt_oe        = 1'b1;
          st_nxt.dt_o         = st_r.tx_hold[0];
        end
        else
          st_nxt.dt_oe = 1'b0;
      end
      uss_pkg::TX_SHIFT:
      begin
        // next bit presented on each falling edge of the master clock
        if (ck_fall)
        begin
          st_nxt.tx_shift_register    = {1'b0, st_r.tx_shift_register[8:1]};
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          st_nxt.dt_o   = st_r.tx_shift_register[1];
          if (st_r.tx_cnt + 4'h1 == txbits)
            st_nxt.tx_st = uss_pkg::TX_LAST;
        end
      end
      uss_pkg::TX_LAST:
      begin
        // word fully out: reload a waiting word or release the pin
        st_nxt.tx_st = uss_pkg::TX_IDLE;
        st_nxt.dt_oe = st_r.tx_hold_full;
      end
      default: st_nxt.tx_st = uss_pkg::TX_IDLE;
    endcase
    if (!slave_on || !st_r.tcs[uss_pkg::TCS_TRANSMIT_ENABLE])
    begin
      st_nxt.tx_st = uss_pkg::TX_IDLE;
      st_nxt.dt_oe = 1'b0;
    end
    // tx flag sets one instruction cycle after the move
    if (st_r.tcy_cnt != 4'h0)
    begin
      st_nxt.tcy_cnt = st_r.tcy_cnt - 4'h1;
      if (st_r.tcy_cnt == 4'h1 && !st_r.tx_hold_full)
        st_nxt.tx_flag = 1'b1;
    end
    // shift-register-empty status mirrors the shifter, polled only
    st_nxt.tcs[uss_pkg::TCS_SHIFT_REG_EMPTY] = (st_nxt.tx_st == uss_pkg::TX_IDLE);

    // receiver: continuous receive only, single receive ignored
    if (slave_on && st_r.rcs[uss_pkg::RCS_CONT_RX_ENABLE] && st_r.tx_st == uss_pkg::TX_IDLE)
    begin
      if (ck_rise)
      begin
        // sampled bit enters at the top, so bit 0 ends lowest
        st_nxt.rx_shift_register    = {st_r.dt_sync[1], st_r.rx_shift_register[8:1]};
        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
        if (st_r.rx_cnt + 4'h1 == rxbits)
        begin
          rx_done       = 1'b1;
          st_nxt.rx_cnt = 4'h0;
        end
      end
    end
    else
      st_nxt.rx_cnt = 4'h0;
    if (rx_done)
    begin
      // unread buffer means overrun; word is dropped
      if (st_r.rx_flag)
        st_nxt.rcs[uss_pkg::RCS_OVERRUN_ERROR] = 1'b1;
      else
      begin
        if (st_r.rcs[uss_pkg::RCS_NINE_BIT_RX])
        begin
          st_nxt.rx_buf                         = st_nxt.rx_shift_register[7:0];
          st_nxt.rcs[uss_pkg::RCS_RX_NINTH_BIT] = st_nxt.rx_shift_register[8];
        end
        else
          st_nxt.rx_buf = st_nxt.rx_shift_register[8:1];
        st_nxt.rx_flag = 1'b1;
      end
    end

    // register writes
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = uss_pkg::RESP_OKAY;
      if (st_r.w_strb[0])
        case (st_r.aw_addr)
          uss_pkg::RX_STATUS_CONTROL_ADDR:
          begin
            st_nxt.rcs[7:3] = wb[7:3];
            // dropping continuous receive clears latched errors; an overrun in the same cycle wins
            if (!wb[uss_pkg::RCS_CONT_RX_ENABLE])
            begin
              st_nxt.rcs[uss_pkg::RCS_OVERRUN_ERROR] = rx_done & st_r.rx_flag;
              st_nxt.rcs[uss_pkg::RCS_FRAMING_ERROR] = 1'b0;
            end
          end
          uss_pkg::TX_HOLDING_ADDR:
          begin
            st_nxt.tx_hold      = wb;
            st_nxt.tx_hold_full = 1'b1;
            st_nxt.tx_flag      = 1'b0;
          end
          uss_pkg::TX_STATUS_CONTROL_ADDR:
          begin
            st_nxt.tcs[7:2] = wb[7:2];
            st_nxt.tcs[0]   = wb[0];
          end
          uss_pkg::BAUD_CONTROL_ADDR:  st_nxt.baud_ctl = (wb & uss_pkg::BAUD_CTL_WMASK) | uss_pkg::BAUD_CTL_RESET;
          uss_pkg::BAUD_DIV_HIGH_ADDR: st_nxt.div_hi   = wb;
          uss_pkg::BAUD_DIV_LOW_ADDR:  st_nxt.div_lo   = wb;
          uss_pkg::IRQ_ENABLES_ADDR:   st_nxt.irq_en   = wb;
          uss_pkg::IRQ_PRIORITY_ADDR:  st_nxt.irq_pri  = wb;
          uss_pkg::POWER_CONTROL_ADDR: st_nxt.pwr      = wb[1:0];
          uss_pkg::IRQ_FLAGS_ADDR,
          uss_pkg::RX_BUFFER_ADDR:     st_nxt.bresp    = uss_pkg::RESP_OKAY;
          default:                     st_nxt.bresp    = uss_pkg::RESP_SLVERR;
        endcase
    end

    // register reads
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (rd_fire)
    begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = uss_pkg::RESP_OKAY;
      st_nxt.rdata   = 32'h0;
      case (s_axi_araddr)
        uss_pkg::RX_STATUS_CONTROL_ADDR: st_nxt.rdata[7:0] = st_r.rcs;
        uss_pkg::TX_STATUS_CONTROL_ADDR: st_nxt.rdata[7:0] = st_r.tcs;
        uss_pkg::BAUD_CONTROL_ADDR:      st_nxt.rdata[7:0] = st_r.baud_ctl;
        uss_pkg::BAUD_DIV_HIGH_ADDR:     st_nxt.rdata[7:0] = st_r.div_hi;
        uss_pkg::BAUD_DIV_LOW_ADDR:      st_nxt.rdata[7:0] = st_r.div_lo;
        uss_pkg::IRQ_FLAGS_ADDR:
        begin
          st_nxt.rdata[uss_pkg::IRQ_RX_BIT] = st_r.rx_flag;
          st_nxt.rdata[uss_pkg::IRQ_TX_BIT] = st_r.tx_flag;
        end
        uss_pkg::IRQ_ENABLES_ADDR:       st_nxt.rdata[7:0] = st_r.irq_en;
        uss_pkg::IRQ_PRIORITY_ADDR:      st_nxt.rdata[7:0] = st_r.irq_pri;
        uss_pkg::POWER_CONTROL_ADDR:     st_nxt.rdata[1:0] = st_r.pwr;
        uss_pkg::TX_HOLDING_ADDR:        st_nxt.rdata      = 32'h0;
        uss_pkg::RX_BUFFER_ADDR:
        begin
          // reading the buffer consumes the word; a new arrival wins
          st_nxt.rdata[7:0] = st_r.rx_buf;
          if (!rx_done)
            st_nxt.rx_flag = 1'b0;
        end
        default:                         st_nxt.rresp      = uss_pkg::RESP_SLVERR;
      endcase
    end

    // interrupt outputs gated by enables; any one wakes the core
    st_nxt.tx_irq = st_nxt.tx_flag & st_nxt.irq_en[uss_pkg::IRQ_TX_BIT];
    st_nxt.rx_irq = st_nxt.rx_flag & st_nxt.irq_en[uss_pkg::IRQ_RX_BIT];
    st_nxt.wake   = (st_nxt.tx_irq | st_nxt.rx_irq) & (st_r.pwr != 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r          <= '0;
      st_r.rcs      <= uss_pkg::RCS_RESET;
      st_r.tcs      <= uss_pkg::TCS_RESET;
      st_r.baud_ctl <= uss_pkg::BAUD_CTL_RESET;
      st_r.tx_st    <= uss_pkg::TX_IDLE;
      st_r.tx_flag  <= 1'b1;
      st_r.awready  <= 1'b1;
      st_r.wready   <= 1'b1;
      st_r.arready  <= 1'b1;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops; shift clock never driven
  assign s_axi_awready      = st_r.awready;
  assign s_axi_wready       = st_r.wready;
  assign s_axi_bvalid       = st_r.bvalid;
  assign s_axi_bresp        = st_r.bresp;
  assign s_axi_arready      = st_r.arready;
  assign s_axi_rvalid       = st_r.rvalid;
  assign s_axi_rdata        = st_r.rdata;
  assign s_axi_rresp        = st_r.rresp;
  assign data_pin_o         = st_r.dt_o;
  assign data_pin_oe        = st_r.dt_oe;
  assign shift_clock_pin_o  = st_r.ck_prev & 1'b0;
  assign shift_clock_pin_oe = st_r.ck_prev & 1'b0;
  assign tx_irq             = st_r.tx_irq;
  assign rx_irq             = st_r.rx_irq;
  assign wake_o             = st_r.wake;
endmodule : uss_top

// *** uss_chk.sv ***
// checker: bus and link timing assertions for the sync slave serial port
`timescale 1ns/10ps
module uss_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        shift_clock_pin_i,
  input wire logic        data_pin_o,
  input wire logic        data_pin_oe,
  input wire logic        shift_clock_pin_o,
  input wire logic        shift_clock_pin_oe,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        wake_o
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // link pin relations
  a_clk_pin_idle: assert property (!shift_clock_pin_oe && !shift_clock_pin_o)
    else $error("slave drove the shift clock pin");
  a_data_after_fall: assert property ($changed(data_pin_o) && data_pin_oe && $past(data_pin_oe)
    |-> !shift_clock_pin_i) else $error("tx data moved while shift clock high");
  a_data_hold_high: assert property (data_pin_oe && $past(data_pin_oe) && shift_clock_pin_i
    && $past(shift_clock_pin_i, 4) |-> $stable(data_pin_o)) else $error("tx data unstable in high phase");
  a_wake_cause: assert property (wake_o |-> tx_irq || rx_irq || $past(tx_irq || rx_irq))
    else $error("wake without a pending interrupt");
  ////////////////////////////////////////////////////////////
  // register bus relations
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // main scenarios reached
  c_tx_start: cover property ($rose(data_pin_oe));
  c_rx_irq: cover property ($rose(rx_irq));
  c_wake: cover property ($rose(wake_o));
endmodule : uss_chk
bind uss_top uss_chk CHK (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .shift_clock_pin_i(shift_clock_pin_i), .data_pin_o(data_pin_o),
  .data_pin_oe(data_pin_oe), .shift_clock_pin_o(shift_clock_pin_o),
  .shift_clock_pin_oe(shift_clock_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_o(wake_o)
);

// *** uss_link_master.sv ***
// link master model: makes the shift clock in frames and drives or samples data
`timescale 1ns/10ps
module uss_link_master (
  input  wire logic aclk,
  input  wire logic dev_d,
  input  wire logic dev_oe,
  output logic      sck,
  output logic      line
);
  logic m_d;
  logic m_oe;
  logic junk;
  // clock stands low outside frames
  initial
  begin
    sck = 1'b0;
    m_d = 1'b0;
    m_oe = 1'b0;
    junk = 1'b0;
  end
  // undriven line shows a pattern that flips every cycle
  always @(posedge aclk) junk <= ~junk;
  assign line = dev_oe ? dev_d : (m_oe ? m_d : junk);
  // one frame of n bits, lsb first, 125 ns clock period
  task automatic frame(input int n, input logic [8:0] w, input logic drv, output logic [8:0] r);
    r = 9'h000;
    #0.25; // keeps every link edge off a core clock edge when the frame starts on a rising core clock edge
    m_oe = drv;
    for (int i = 0; i < n; i++)
    begin
      m_d = w[i];
      #62.5 sck = 1'b1;
      r[i] = line;
      #62.5 sck = 1'b0;
    end
    #62.5 m_oe = 1'b0;
  endtask : frame
endmodule : uss_link_master

// *** tb.sv ***
// testbench: register, transmit and receive scenarios for the sync slave port
`timescale 1ns/10ps
module tb;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr, a, b;
  logic [31:0] wdata, rdata, d, cfg;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, t9;
  logic        sck, line, d_o, d_oe, ck_o, ck_oe, tx_irq, rx_irq, wake;
  logic [8:0]  w, got;
  int          err_total, n_checks, seed, n;
  // 250 mhz core clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  uss_top DUT (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shift_clock_pin_i(sck), .data_pin_i(line), .data_pin_o(d_o), .data_pin_oe(d_oe),
    .shift_clock_pin_o(ck_o), .shift_clock_pin_oe(ck_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_o(wake)
  );
  uss_link_master PM (.aclk(aclk), .dev_d(d_o), .dev_oe(d_oe), .sck(sck), .line(line));
  ////////////////////////////////////////////////////////////
  // verdict and run end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  // a bus wait that ran out
  task automatic hang;
    $display("ERROR bus answer expected 1 seen 0");
    err_total++;
    wrap_up();
  endtask : hang
  // axi4-lite write, address and data offered together
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    int   k;
    logic aw_t, w_t, b_t;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) break;
    end
    bready <= 1'b0;
    if (k == 64) hang();
    chk("bresp", 32'(uss_pkg::RESP_OKAY), 32'(rs));
    @(posedge aclk);
  endtask : axw
  // axi4-lite read
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] re);
    int   k;
    logic ar_t, r_t;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++)
    begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      dt = rdata;
      re = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) break;
    end
    rready <= 1'b0;
    if (k == 64) hang();
    @(posedge aclk);
  endtask : axr
  // read a register and compare it
  task automatic rc(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    axr(ad, v, r);
    chk($sformatf("resp %h", ad), 32'(uss_pkg::RESP_OKAY), 32'(r));
    chk($sformatf("reg %h", ad), e, v);
  endtask : rc
  // expected word on the wire
  function automatic logic [31:0] fexp(input int nb, input logic [7:0] by, input logic x);
    fexp = (nb == 9) ? {23'h0, x, by} : {24'h0, by};
  endfunction : fexp
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    {err_total, n_checks, seed} = {32'h0, 32'h0, 32'h7561};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(uss_pkg::RX_STATUS_CONTROL_ADDR, 32'(uss_pkg::RCS_RESET));
    rc(uss_pkg::TX_STATUS_CONTROL_ADDR, 32'(uss_pkg::TCS_RESET));
    rc(uss_pkg::IRQ_FLAGS_ADDR, 32'h10);
    axr(8'h2c, d, rs);
    chk("unmapped resp", 32'(uss_pkg::RESP_SLVERR), 32'(rs));
    chk("unmapped data", 32'h0, d);
    // two words queued before sleep, 8 and 9 bit
    axw(uss_pkg::RX_STATUS_CONTROL_ADDR, 32'h80);
    axw(uss_pkg::IRQ_ENABLES_ADDR, 32'h10);
    for (n = 8; n <= 9; n++)
    begin
      {a, b, t9} = 17'($random(seed));
      cfg = 32'h30 | ((n == 9) ? 32'h40 : 32'h0) | 32'(t9);
      axw(uss_pkg::TX_STATUS_CONTROL_ADDR, cfg);
      axw(uss_pkg::TX_HOLDING_ADDR, 32'(a));
      axw(uss_pkg::TX_HOLDING_ADDR, 32'(b));
      rc(uss_pkg::IRQ_FLAGS_ADDR, 32'h00);
      axw(uss_pkg::POWER_CONTROL_ADDR, 32'h1);
      PM.frame(n, 9'h0, 1'b0, got);
      chk("first word", fexp(n, a, t9), 32'(got));
      repeat (20) @(posedge aclk);
      rc(uss_pkg::IRQ_FLAGS_ADDR, 32'h10);
      chk("wake", 32'h1, 32'(wake));
      chk("tx_irq", 32'h1, 32'(tx_irq));
      rc(uss_pkg::TX_STATUS_CONTROL_ADDR, cfg);
      PM.frame(n, 9'h0, 1'b0, got);
      chk("second word", fexp(n, b, t9), 32'(got));
      repeat (20) @(posedge aclk);
      rc(uss_pkg::TX_STATUS_CONTROL_ADDR, cfg | 32'h2);
    end
    // reception in idle, single enable set and ignored
    axw(uss_pkg::TX_STATUS_CONTROL_ADDR, 32'h10);
    axw(uss_pkg::IRQ_ENABLES_ADDR, 32'h20);
    axw(uss_pkg::POWER_CONTROL_ADDR, 32'h2);
    // received ninth bit stays latched until the next nine-bit word
    t9 = 1'b0;
    for (n = 8; n <= 10; n++)
    begin
      cfg = (n == 9) ? 32'hf0 : 32'hb0;
      axw(uss_pkg::RX_STATUS_CONTROL_ADDR, cfg);
      w = 9'($random(seed));
      if (n == 9) t9 = w[8];
      PM.frame((n == 9) ? 9 : 8, w, 1'b1, got);
      if (n == 10) PM.frame(8, ~w, 1'b1, got);
      repeat (20) @(posedge aclk);
      chk("rx_irq", 32'h1, 32'(rx_irq));
      chk("wake", 32'h1, 32'(wake));
      rc(uss_pkg::RX_STATUS_CONTROL_ADDR, cfg | 32'(t9) | ((n == 10) ? 32'h2 : 32'h0));
      rc(uss_pkg::RX_BUFFER_ADDR, 32'(w[7:0]));
      rc(uss_pkg::IRQ_FLAGS_ADDR, 32'h10);
    end
    axw(uss_pkg::RX_STATUS_CONTROL_ADDR, 32'ha0);
    rc(uss_pkg::RX_STATUS_CONTROL_ADDR, 32'ha0 | 32'(t9));
    // clock source set: no slave shifting
    axw(uss_pkg::TX_STATUS_CONTROL_ADDR, 32'hb0);
    axw(uss_pkg::TX_HOLDING_ADDR, 32'($random(seed)) & 32'hff);
    repeat (20) @(posedge aclk);
    chk("data oe", 32'h0, 32'(d_oe));
    chk("clock pin", 32'h0, 32'({ck_o, ck_oe}));
    wrap_up();
  end
endmodule : tb
